// ### design/spread_pkg.sv
/*
 Constants, field layouts, reset values and carrier types for the
 spread-spectrum packet framer and hop controller.
 Assumes a 200 MHz system clock; no other file defines these numbers.
*/
// Notes on behaviour
// - Symbol rate is bandwidth over two to the spreading factor; one chip per Hz.
// - Packet is preamble, optional header, payload, optional payload CRC.
// - Preamble length resets to 12 symbols.
// - 16-bit preamble length from two bytes, 6 to 65535, plus 4 fixed symbols; the 16-bit end count wraps for lengths above 65532, cutting the preamble short.
// - One implicit-header bit picks header type; explicit when clear and at reset.
// - Explicit header carries payload length, code rate and payload CRC flag.
// - Header always sent at code rate 4/8 with its own CRC.
// - Implicit mode sends no header; both ends configured alike.
// - Preamble lasts programmed length plus 4.25 symbol periods.
// - Payload symbols are 8 plus the ceiling expression times code rate plus 4.
// - Hopping active when dwell field is non-zero, off when zero.
// - Dwell per channel is dwell field times symbol period.
// - Hopping transmit starts on channel 0; preamble and header stay there.
// - Each hop increments present channel and raises the change flag.
// - Host reprograms next frequency then clears flag by writing 1.
// - Hopping receive starts on channel 0, hops only after preamble detect; after a packet end the code goes back to preamble search on the last channel.
// - Header CRC failure returns receiver to channel 0 and preamble search.
// - Configuration always readable; writes only in sleep or standby.
// - Long-range mode hides the sequencer and switches register layout.
// - Code-rate field 1 to 4 means 4/5, 4/6, 4/7, 4/8.
package spread_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned BW125_HZ = 125_000;
	localparam int unsigned BW250_HZ = 250_000;
	localparam int unsigned BW500_HZ = 500_000;
	localparam logic [11:0] CHIP_CYC_125 = 12'(CLK_HZ / BW125_HZ);
	localparam logic [11:0] CHIP_CYC_250 = 12'(CLK_HZ / BW250_HZ);
	localparam logic [11:0] CHIP_CYC_500 = 12'(CLK_HZ / BW500_HZ);
	localparam logic [1:0] BW_125 = 2'h0;
	localparam logic [1:0] BW_250 = 2'h1;

	localparam logic [15:0] PRE_LEN_RST = 16'h000c;
	localparam logic [15:0] PRE_LEN_MIN = 16'h0006;
	localparam logic [15:0] PRE_FIXED = 16'h0004;
	localparam logic [11:0] HDR_SYMS = 12'h008;
	localparam logic [2:0] HDR_CR = 3'h4;
	localparam logic [11:0] PAY_BASE = 12'h008;
	localparam logic signed [13:0] TOA_CONST = 14'sh001c;

	// Config port selectors
	localparam logic [2:0] SEL_PRE_HI = 3'h0;
	localparam logic [2:0] SEL_PRE_LO = 3'h1;
	localparam logic [2:0] SEL_MCFG1 = 3'h2;
	localparam logic [2:0] SEL_MCFG2 = 3'h3;
	localparam logic [2:0] SEL_PAYLEN = 3'h4;
	localparam logic [2:0] SEL_HOPDW = 3'h5;
	localparam logic [2:0] SEL_HOPCH = 3'h6;

	// modem_cfg_first fields
	localparam int IMPL_BIT = 0;
	localparam int CRC_BIT = 1;
	localparam int CR_LSB = 2;
	localparam int SLOW_BIT = 5;
	// second modem config fields
	localparam int SF_LSB = 0;
	localparam int BW_LSB = 4;
	localparam int FLAG_BIT = 7;

	localparam logic [7:0] MCFG1_RST = 8'h04;
	localparam logic [7:0] MCFG2_RST = 8'h07;
	localparam logic [7:0] PAYLEN_RST = 8'h01;
	localparam logic [7:0] HOPDW_RST = 8'h00;

	localparam logic [1:0] OP_SLEEP = 2'h0;
	localparam logic [1:0] OP_STBY = 2'h1;
	localparam logic [1:0] OP_TX = 2'h2;
	localparam logic [1:0] OP_RX = 2'h3;

	typedef struct packed {
		logic [15:0] pre_len;
		logic implicit_header_sel;
		logic crc_on;
		logic [2:0] code_rate_field;
		logic slow_rate_robust_en;
		logic [3:0] spreading_factor;
		logic [1:0] signal_bandwidth;
		logic [7:0] pay_len;
		logic [7:0] hop_dwell_symbols;
	} cfg_t;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_PRE = 8'h02,
		ST_PREQ = 8'h04,
		ST_HDR = 8'h08,
		ST_PAY = 8'h10,
		ST_RXS = 8'h20,
		ST_RXH = 8'h40,
		ST_RXP = 8'h80
	} state_t;
endpackage

// ### design/tick_div.sv
/*
 Restartable divider producing a one-cycle enable every limit input pulses.
 Assumes limit is at least 1 and is held steady while counting.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_div #(
	parameter int W = 12
) (
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_clr,
	input wire logic i_en,
	input wire logic [W-1:0] i_limit,
	// Result
	output logic o_tick
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge i_clk) begin
		if (i_rst || i_clr) begin
			cnt_q <= '0;
			o_tick <= 1'b0;
		end else if (i_en) begin
			if (cnt_q >= i_limit - W'(1)) begin
				cnt_q <= '0;
				o_tick <= 1'b1;
			end else begin
				cnt_q <= cnt_q + W'(1);
				o_tick <= 1'b0;
			end
		end else begin
			o_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### design/spread_packet_hop_control.sv
/*
 Packet framing sequencer and frequency-hop controller of the
 long-range modem: symbol timing, preamble/header/payload phases,
 payload symbol count, hop channel counter and change flag.
 Assumes demodulator events and mode inputs are on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module spread_packet_hop_control
	import spread_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	// Operating mode
	input wire logic [1:0] i_op_mode,
	input wire logic i_long_range,
	// Configuration port
	input wire logic i_cfg_wr,
	input wire logic [2:0] i_cfg_sel,
	input wire logic [7:0] i_cfg_wdata,
	output logic [7:0] o_cfg_rdata,
	input wire logic i_hop_clr,
	// Modem events
	input wire logic i_tx_start,
	input wire logic i_preamble_det,
	input wire logic i_header_ok,
	input wire logic i_header_crc_err,
	input wire logic i_rx_done,
	// Status
	output logic [7:0] o_phase,
	output logic o_sym_tick,
	output logic [2:0] o_code_rate,
	output logic o_busy,
	output logic o_done,
	output logic [11:0] o_pay_syms,
	output logic [5:0] o_current_hop_channel,
	output logic o_hop_change_flag,
	output logic o_top_level_sequencer,
	output logic o_map_long_range
);
	cfg_t cfg_q;
	state_t st_q;
	logic [15:0] sym_cnt_q;
	logic [11:0] npay_q;
	logic [7:0] dwell_q;
	logic hop_run_q;
	logic [5:0] chan_q;
	logic flag_q;
	logic chip_tick;
	logic sym_tick;
	logic wr_ok;
	logic start_tx;
	logic start_rx;
	logic restart;
	logic [11:0] chip_cyc;
	logic [12:0] sym_lim;
	logic [15:0] pre_eff;
	logic hop_step;

	// Writes only land in sleep or standby
	assign wr_ok = i_cfg_wr && (i_op_mode == OP_SLEEP || i_op_mode == OP_STBY);
	assign start_tx = (st_q == ST_IDLE) && i_long_range && i_op_mode == OP_TX
		&& i_tx_start;
	assign start_rx = (st_q == ST_IDLE) && i_long_range && i_op_mode == OP_RX;
	assign restart = start_tx || start_rx;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cfg_q.pre_len <= PRE_LEN_RST;
			cfg_q.implicit_header_sel <= MCFG1_RST[IMPL_BIT];
			cfg_q.crc_on <= MCFG1_RST[CRC_BIT];
			cfg_q.code_rate_field <= MCFG1_RST[CR_LSB +: 3];
			cfg_q.slow_rate_robust_en <= MCFG1_RST[SLOW_BIT];
			cfg_q.spreading_factor <= MCFG2_RST[SF_LSB +: 4];
			cfg_q.signal_bandwidth <= MCFG2_RST[BW_LSB +: 2];
			cfg_q.pay_len <= PAYLEN_RST;
			cfg_q.hop_dwell_symbols <= HOPDW_RST;
		end else if (wr_ok) begin
			unique case (i_cfg_sel)
				SEL_PRE_HI: cfg_q.pre_len[15:8] <= i_cfg_wdata;
				SEL_PRE_LO: cfg_q.pre_len[7:0] <= i_cfg_wdata;
				SEL_MCFG1: begin
					cfg_q.implicit_header_sel <= i_cfg_wdata[IMPL_BIT];
					cfg_q.crc_on <= i_cfg_wdata[CRC_BIT];
					cfg_q.code_rate_field <= i_cfg_wdata[CR_LSB +: 3];
					cfg_q.slow_rate_robust_en <= i_cfg_wdata[SLOW_BIT];
				end
				SEL_MCFG2: begin
					cfg_q.spreading_factor <= i_cfg_wdata[SF_LSB +: 4];
					cfg_q.signal_bandwidth <= i_cfg_wdata[BW_LSB +: 2];
				end
				SEL_PAYLEN: cfg_q.pay_len <= i_cfg_wdata;
				SEL_HOPDW: cfg_q.hop_dwell_symbols <= i_cfg_wdata;
				default: ;
			endcase
		end
	end

	// Readback works in every mode; channel counter is read-only
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_cfg_rdata <= 8'h00;
		end else begin
			unique case (i_cfg_sel)
				SEL_PRE_HI: o_cfg_rdata <= cfg_q.pre_len[15:8];
				SEL_PRE_LO: o_cfg_rdata <= cfg_q.pre_len[7:0];
				SEL_MCFG1: o_cfg_rdata <= {2'h0, cfg_q.slow_rate_robust_en,
					cfg_q.code_rate_field, cfg_q.crc_on, cfg_q.implicit_header_sel};
				SEL_MCFG2: o_cfg_rdata <= {2'h0, cfg_q.signal_bandwidth,
					cfg_q.spreading_factor};
				SEL_PAYLEN: o_cfg_rdata <= cfg_q.pay_len;
				SEL_HOPDW: o_cfg_rdata <= cfg_q.hop_dwell_symbols;
				SEL_HOPCH: o_cfg_rdata <= {flag_q, 1'b0, chan_q};
				default: o_cfg_rdata <= 8'h00;
			endcase
		end
	end

	// Sequencer exists only outside long-range mode; layout follows the mode
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_top_level_sequencer <= 1'b1;
			o_map_long_range <= 1'b0;
		end else begin
			o_top_level_sequencer <= !i_long_range;
			o_map_long_range <= i_long_range;
		end
	end

	// One chip per bandwidth period, 2^SF chips per symbol
	always_comb begin
		unique case (cfg_q.signal_bandwidth)
			BW_125: chip_cyc = CHIP_CYC_125;
			BW_250: chip_cyc = CHIP_CYC_250;
			default: chip_cyc = CHIP_CYC_500;
		endcase
		sym_lim = 13'h0001 << cfg_q.spreading_factor;
		if (st_q == ST_PREQ) begin
			sym_lim = sym_lim >> 2;
		end
	end

	tick_div #(.W(12)) u_chip_div (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clr(restart),
		.i_en(st_q != ST_IDLE),
		.i_limit(chip_cyc),
		.o_tick(chip_tick)
	);

	tick_div #(.W(13)) u_sym_div (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clr(restart),
		.i_en(chip_tick),
		.i_limit(sym_lim),
		.o_tick(sym_tick)
	);

	// Payload symbol count, kept current from the configuration
	always_ff @(posedge i_clk) begin : pay_calc
		logic signed [13:0] num;
		logic [6:0] den;
		logic [11:0] q;
		num = 14'sh0000;
		den = 7'h00;
		q = 12'h000;
		if (i_rst) begin
			npay_q <= PAY_BASE;
		end else begin
			num = $signed({3'h0, cfg_q.pay_len, 3'h0}) + TOA_CONST
				+ $signed({9'h0, cfg_q.crc_on, 4'h0})
				- $signed({8'h0, cfg_q.spreading_factor, 2'h0})
				- (cfg_q.implicit_header_sel ? 14'sh0014 : 14'sh0000);
			den = 7'({cfg_q.spreading_factor, 2'h0})
				- (cfg_q.slow_rate_robust_en ? 7'h08 : 7'h00);
			if (num > 14'sh0000 && den != 7'h00) begin
				q = 12'((num + $signed({7'h0, den}) - 14'sh0001)
					/ $signed({7'h0, den}));
			end
			npay_q <= PAY_BASE + 12'(q * (12'(cfg_q.code_rate_field) + 12'h004));
		end
	end

	assign pre_eff = (cfg_q.pre_len < PRE_LEN_MIN) ? PRE_LEN_MIN : cfg_q.pre_len;

	// Packet phase sequencer
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= ST_IDLE;
			sym_cnt_q <= 16'h0000;
		end else if (st_q != ST_IDLE && st_q != ST_PRE && st_q != ST_PREQ
			&& st_q != ST_HDR && st_q != ST_PAY && i_op_mode != OP_RX) begin
			st_q <= ST_IDLE;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					sym_cnt_q <= 16'h0000;
					if (start_tx) begin
						st_q <= ST_PRE;
					end else if (start_rx) begin
						st_q <= ST_RXS;
					end
				end
				ST_PRE: if (sym_tick) begin
					if (sym_cnt_q == pre_eff + PRE_FIXED - 16'h0001) begin
						st_q <= ST_PREQ;
						sym_cnt_q <= 16'h0000;
					end else begin
						sym_cnt_q <= sym_cnt_q + 16'h0001;
					end
				end
				ST_PREQ: if (sym_tick) begin
					st_q <= cfg_q.implicit_header_sel ? ST_PAY : ST_HDR;
				end
				ST_HDR: if (sym_tick) begin
					sym_cnt_q <= sym_cnt_q + 16'h0001;
					if (sym_cnt_q == {4'h0, HDR_SYMS} - 16'h0001) begin
						st_q <= ST_PAY;
					end
				end
				ST_PAY: if (sym_tick) begin
					sym_cnt_q <= sym_cnt_q + 16'h0001;
					if (sym_cnt_q >= {4'h0, npay_q} - 16'h0001) begin
						st_q <= ST_IDLE;
					end
				end
				ST_RXS: if (i_preamble_det) begin
					st_q <= cfg_q.implicit_header_sel ? ST_RXP : ST_RXH;
				end
				ST_RXH: begin
					if (i_header_crc_err) begin
						st_q <= ST_RXS;
					end else if (i_header_ok) begin
						st_q <= ST_RXP;
					end
				end
				ST_RXP: if (i_rx_done) begin
					st_q <= ST_RXS;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Hop engine: dwell counted in whole symbols
	assign hop_step = hop_run_q && sym_tick
		&& dwell_q == cfg_q.hop_dwell_symbols - 8'h01;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hop_run_q <= 1'b0;
			dwell_q <= 8'h00;
			chan_q <= 6'h00;
		end else if (restart || (st_q == ST_RXH && i_header_crc_err)) begin
			hop_run_q <= 1'b0;
			dwell_q <= 8'h00;
			chan_q <= 6'h00;
		end else begin
			if (cfg_q.hop_dwell_symbols == 8'h00 || st_q == ST_IDLE
				|| st_q == ST_RXS) begin
				hop_run_q <= 1'b0;
			end else if ((st_q == ST_PAY) || (st_q == ST_RXH) || (st_q == ST_RXP)) begin
				hop_run_q <= 1'b1;
			end
			if (!hop_run_q || hop_step) begin
				dwell_q <= 8'h00;
			end else if (sym_tick) begin
				dwell_q <= dwell_q + 8'h01;
			end
			if (hop_step) begin
				chan_q <= chan_q + 6'h01;
			end
		end
	end

	// Change flag: a hop in the clearing cycle keeps it set
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flag_q <= 1'b0;
		end else if (hop_step) begin
			flag_q <= 1'b1;
		end else if (i_hop_clr) begin
			flag_q <= 1'b0;
		end
	end

	// Registered status outputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_phase <= ST_IDLE;
			o_sym_tick <= 1'b0;
			o_code_rate <= MCFG1_RST[CR_LSB +: 3];
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_pay_syms <= PAY_BASE;
			o_current_hop_channel <= 6'h00;
			o_hop_change_flag <= 1'b0;
		end else begin
			o_phase <= st_q;
			o_sym_tick <= sym_tick;
			o_code_rate <= (st_q == ST_HDR || st_q == ST_RXH) ? HDR_CR
				: cfg_q.code_rate_field;
			o_busy <= st_q != ST_IDLE;
			o_done <= (st_q == ST_PAY && sym_tick
				&& sym_cnt_q >= {4'h0, npay_q} - 16'h0001)
				|| (st_q == ST_RXP && i_rx_done);
			o_pay_syms <= npay_q;
			o_current_hop_channel <= chan_q;
			o_hop_change_flag <= flag_q;
		end
	end
endmodule
`default_nettype wire

// ### verification/spread_hop_chk.sv
/*
 Assertion checker for the packet framer and hop controller.
 Bound to the top module; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module spread_hop_chk
	import spread_pkg::*;
(
	// Clock, reset and controls
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [1:0] i_op_mode,
	input wire logic i_long_range,
	input wire logic [2:0] i_cfg_sel,
	input wire logic i_hop_clr,
	input wire logic i_tx_start,
	// Status
	input wire logic [7:0] o_phase,
	input wire logic [7:0] o_cfg_rdata,
	input wire logic o_busy,
	input wire logic [5:0] o_current_hop_channel,
	input wire logic o_hop_change_flag,
	input wire logic o_top_level_sequencer,
	input wire logic o_map_long_range
);
	logic [5:0] ch;
	assign ch = o_current_hop_channel;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_start;
		i_tx_start && !o_busy && i_op_mode == OP_TX && i_long_range;
	endsequence
	sequence s_pre;
		##2 o_busy && o_phase == 8'h02;
	endsequence
	AST_START: assert property (s_start |-> s_pre)
		else $error("start not followed by preamble phase");
	AST_ONEHOT: assert property ($onehot(o_phase) && o_busy == (o_phase != 8'h01))
		else $error("phase not one-hot or busy wrong");
	AST_TLS: assert property (o_top_level_sequencer != o_map_long_range)
		else $error("sequencer visible in long-range map");
	AST_CH_STEP: assert property ($changed(ch) |-> ch == $past(ch) + 6'h01 || ch == 6'h00)
		else $error("channel moved by other than one");
	AST_FLAG_SET: assert property ($changed(ch) && ch != 6'h00 |-> ##[0:1] o_hop_change_flag)
		else $error("hop without change flag");
	// The clear reaches the output flag two edges after it is sampled
	AST_FLAG_HOLD: assert property (o_hop_change_flag && !i_hop_clr && !$past(i_hop_clr)
		|=> o_hop_change_flag)
		else $error("change flag dropped without clear");
	AST_FLAG_CLR: assert property (o_hop_change_flag && i_hop_clr && $stable(ch)
		|-> ##2 (!o_hop_change_flag || $changed(ch)))
		else $error("change flag not cleared");
	AST_FLAG_RISE: assert property ($rose(o_hop_change_flag)
		|-> ch != $past(ch) || ch != $past(ch, 2))
		else $error("change flag rose without hop");
	AST_PRE_CH0: assert property (o_phase == 8'h02 && $past(o_phase) == 8'h02 |-> ch == 6'h00)
		else $error("preamble not on channel zero");
	AST_RD_NONE: assert property (i_cfg_sel == 3'h7 |=> o_cfg_rdata == 8'h00)
		else $error("unused selector reads nonzero");
endmodule
`default_nettype wire

// ### verification/far_radio.sv
/*
 Remote radio model: turns bench event codes into demodulator pulses.
 Assumes the bench holds a code for one clock cycle only.
*/
`timescale 1ns/1ps
`default_nettype none
module far_radio (
	// Event code: 1 preamble, 2 header ok, 3 header crc fail, 4 packet end
	input wire logic [2:0] i_ev,
	// Demodulator pulses
	output logic o_preamble_det,
	output logic o_header_ok,
	output logic o_header_crc_err,
	output logic o_rx_done
);
	assign o_preamble_det = i_ev == 3'h1;
	assign o_header_ok = i_ev == 3'h2;
	assign o_header_crc_err = i_ev == 3'h3;
	assign o_rx_done = i_ev == 3'h4;
endmodule
`default_nettype wire

// ### verification/spread_packet_hop_control_tb.sv
/*
 Self-checking bench for the packet framer and hop controller.
 Assumes the remote radio model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module spread_packet_hop_control_tb
	import spread_pkg::*;
;
	logic i_clk, i_rst, i_long_range, i_cfg_wr, i_hop_clr, i_tx_start;
	logic [1:0] i_op_mode;
	logic [2:0] i_cfg_sel, ev;
	logic [7:0] i_cfg_wdata, o_cfg_rdata, o_phase;
	logic i_preamble_det, i_header_ok, i_header_crc_err, i_rx_done;
	logic o_sym_tick, o_busy, o_done, o_hop_change_flag;
	logic o_top_level_sequencer, o_map_long_range;
	logic [2:0] o_code_rate;
	logic [11:0] o_pay_syms;
	logic [5:0] o_current_hop_channel;
	int checks = 0;
	int error_cnt = 0;
	int cyc = 0;
	int t1;
	int nsym = 0;
	int s1;
	spread_packet_hop_control uut (.*);
	far_radio radio (.i_ev(ev), .o_preamble_det(i_preamble_det), .o_header_ok(i_header_ok),
		.o_header_crc_err(i_header_crc_err), .o_rx_done(i_rx_done));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) cyc <= cyc + 1;
	always @(posedge i_clk) if (o_sym_tick) nsym <= nsym + 1;
	task automatic tick(int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic summarize();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr_reg(logic [2:0] s, logic [7:0] d);
		i_cfg_sel <= s;
		i_cfg_wdata <= d;
		i_cfg_wr <= 1'b1;
		tick(1);
		i_cfg_wr <= 1'b0;
		tick(1);
	endtask
	task automatic rd(logic [2:0] s, logic [7:0] e);
		i_cfg_sel <= s;
		tick(2);
		`CHK(o_cfg_rdata, e)
	endtask
	task automatic pulse(logic [2:0] e);
		ev <= e;
		tick(1);
		ev <= 3'h0;
		tick(3);
	endtask
	task automatic wait_ch(logic [5:0] v);
		int k;
		k = 0;
		while (o_current_hop_channel !== v && k < 40000) begin
			tick(1);
			k++;
		end
		if (k >= 40000) error_cnt++;
	endtask
	function automatic int npay(int pl, int sf, int crc, int ih, int de, int cr);
		int num;
		int den;
		num = 8 * pl - 4 * sf + 28 + 16 * crc - 20 * ih;
		den = 4 * (sf - 2 * de);
		return 8 + (num > 0 ? (num + den - 1) / den : 0) * (cr + 4);
	endfunction
	task automatic cfg(int pl, int sf, int bw, int ih, int crc, int cr, int de, int dw);
		wr_reg(SEL_MCFG1, 8'(ih | crc << 1 | cr << 2 | de << 5));
		wr_reg(SEL_MCFG2, 8'(sf | bw << 4));
		wr_reg(SEL_PAYLEN, 8'(pl));
		wr_reg(SEL_HOPDW, 8'(dw));
		tick(2);
		`CHK(o_pay_syms, 12'(npay(pl, sf, crc, ih, de, cr)))
	endtask
	initial begin
		tick(95000);
		error_cnt++;
		summarize();
	end
	initial begin
		{i_rst, i_long_range} = 2'h3;
		{i_op_mode, i_cfg_wr, i_cfg_sel, i_cfg_wdata, i_hop_clr, i_tx_start, ev} = '0;
		tick(12);
		i_rst <= 1'b0;
		tick(1);
		rd(SEL_PRE_HI, 8'h00);
		rd(SEL_PRE_LO, 8'h0c);
		rd(SEL_MCFG1, 8'h04);
		rd(SEL_HOPDW, 8'h00);
		rd(SEL_HOPCH, 8'h00);
		rd(3'h7, 8'h00);
		`CHK(o_code_rate, 3'h1)
		`CHK(o_top_level_sequencer, 1'b0)
		wr_reg(SEL_PRE_HI, 8'h12);
		wr_reg(SEL_PRE_LO, 8'h34);
		rd(SEL_PRE_HI, 8'h12);
		rd(SEL_PRE_LO, 8'h34);
		i_op_mode <= OP_TX;
		wr_reg(SEL_PRE_LO, 8'h56);
		rd(SEL_PRE_LO, 8'h34);
		i_op_mode <= OP_SLEEP;
		wr_reg(SEL_HOPCH, 8'h3f);
		rd(SEL_HOPCH, 8'h00);
		for (int c = 1; c <= 4; c++) begin
			wr_reg(SEL_MCFG1, 8'(c << 2));
			tick(2);
			`CHK(o_code_rate, 3'(c))
		end
		i_long_range <= 1'b0;
		tick(3);
		`CHK(o_top_level_sequencer, 1'b1)
		`CHK(o_map_long_range, 1'b0)
		i_long_range <= 1'b1;
		tick(3);
		cfg(1, 7, 0, 0, 0, 1, 0, 0);
		cfg(255, 12, 0, 0, 1, 4, 1, 0);
		cfg(64, 9, 1, 1, 0, 3, 0, 0);
		cfg(4, 6, 2, 1, 1, 2, 0, 1);
		i_op_mode <= OP_TX;
		tick(1);
		i_tx_start <= 1'b1;
		tick(1);
		i_tx_start <= 1'b0;
		tick(3);
		`CHK(o_phase, 8'h02)
		`CHK(o_busy, 1'b1)
		`CHK(o_current_hop_channel, 6'h00)
		rd(SEL_PAYLEN, 8'h04);
		i_rst <= 1'b1;
		tick(2);
		i_rst <= 1'b0;
		i_op_mode <= OP_STBY;
		tick(1);
		// Fastest symbol: 64 chips at 500 kHz, one symbol dwell, no header
		cfg(4, 6, 2, 1, 0, 1, 0, 1);
		wr_reg(SEL_PRE_HI, 8'hff);
		wr_reg(SEL_PRE_LO, 8'hff);
		i_op_mode <= OP_RX;
		tick(26000);
		`CHK(o_phase, 8'h20)
		`CHK(o_current_hop_channel, 6'h00)
		pulse(3'h1);
		`CHK(o_phase, 8'h80)
		wait_ch(6'h01);
		t1 = cyc;
		s1 = nsym;
		tick(2);
		`CHK(o_hop_change_flag, 1'b1)
		tick(100);
		`CHK(o_hop_change_flag, 1'b1)
		i_hop_clr <= 1'b1;
		tick(1);
		i_hop_clr <= 1'b0;
		tick(2);
		`CHK(o_hop_change_flag, 1'b0)
		wait_ch(6'h02);
		`CHK(cyc - t1, (CLK_HZ / 500_000) << 6)
		`CHK(nsym - s1, 1)
		i_op_mode <= OP_STBY;
		tick(3);
		`CHK(o_phase, 8'h01)
		cfg(4, 7, 2, 0, 0, 1, 0, 1);
		i_op_mode <= OP_RX;
		tick(3);
		pulse(3'h1);
		`CHK(o_phase, 8'h40)
		`CHK(o_current_hop_channel, 6'h00)
		pulse(3'h3);
		`CHK(o_phase, 8'h20)
		`CHK(o_current_hop_channel, 6'h00)
		pulse(3'h1);
		pulse(3'h2);
		`CHK(o_phase, 8'h80)
		ev <= 3'h4;
		tick(1);
		ev <= 3'h0;
		tick(1);
		`CHK(o_done, 1'b1)
		tick(1);
		`CHK(o_done, 1'b0)
		tick(1);
		`CHK(o_phase, 8'h20)
		summarize();
	end
endmodule
bind spread_packet_hop_control spread_hop_chk chk (.*);
`default_nettype wire
